// ---- inc/iqp_pkg.sv ----
// constants for the isa i/o host port with event report queue
// How it works
// - pointer bits 11..0 address selected register
// - pointer bits 14..12 read 011, writes ignored
// - pointer bit 15 selects auto-increment
// - auto-increment advances pointer one word per access
// - port 0 low word, port 1 high word; with auto-increment both use the pointer
// - respond only aen low and address hit
// - bus state bit 8 reports space available
// - space event interrupts when buffer config enables
// - bus state bit 7 flags bad length
// - receive readout gives status, length, then data
// - event sets register, queues report, raises request
// - many rx/tx reports, one of others
// - reports leave in fixed priority order
// - queue read clears reported event register (miss/collision counters kept), advances
// - empty queue reads zero word
// - queue word: number low six, contents upper ten
// - request only with global enable bit 15
// - first read drops request; hold 1.6 us
// - select register picks pin or tri-states all
// - only frame data from destination onward transferred
// - sixteen locations, base 300h after reset
package iqp_pkg;
  // i/o port offsets inside the 16-location window
  localparam logic [3:0] OFS_FRAME0 = 4'h0;
  localparam logic [3:0] OFS_FRAME1 = 4'h2;
  localparam logic [3:0] OFS_TRANSMIT_COMMAND_WORD = 4'h4;
  localparam logic [3:0] OFS_TXLEN = 4'h6;
  localparam logic [3:0] OFS_QUEUE = 4'h8;
  localparam logic [3:0] OFS_PTR = 4'ha;
  localparam logic [3:0] OFS_DATA0 = 4'hc;
  localparam logic [3:0] OFS_DATA1 = 4'he;
  localparam logic [15:0] IO_BASE_RST = 16'h0300;
  // pointer fields
  localparam int PTR_AINC_BIT = 15;
  localparam logic [2:0] PTR_FIXED = 3'b011;
  localparam logic [11:0] PTR_STEP = 12'h002;
  // internal register addresses
  localparam logic [11:0] A_IRQ_NUM = 12'h022;
  localparam logic [11:0] A_BUF_CFG = 12'h10a;
  localparam logic [11:0] A_BUS_CTL = 12'h116;
  localparam logic [11:0] A_QUEUE = 12'h120;
  localparam logic [11:0] A_RX_EV = 12'h124;
  localparam logic [11:0] A_TX_EV = 12'h128;
  localparam logic [11:0] A_BUF_EV = 12'h12c;
  localparam logic [11:0] A_MISS = 12'h130;
  localparam logic [11:0] A_COL = 12'h132;
  localparam logic [11:0] A_BUS_ST = 12'h138;
  localparam logic [11:0] A_RX_STAT = 12'h400;
  localparam logic [11:0] A_RX_LEN = 12'h402;
  // report register numbers
  localparam logic [5:0] N_RX_EV = 6'h04;
  localparam logic [5:0] N_TX_EV = 6'h08;
  localparam logic [5:0] N_BUF_EV = 6'h0c;
  localparam logic [5:0] N_MISS = 6'h10;
  localparam logic [5:0] N_COL = 6'h12;
  localparam logic [5:0] N_BUF_CFG = 6'h0b;
  localparam logic [5:0] N_BUS_CTL = 6'h17;
  localparam logic [5:0] N_BUS_ST = 6'h18;
  // field positions
  localparam int BUS_CTL_IRQ_EN = 15;
  localparam int BUS_ST_SPACE = 8;
  localparam int BUS_ST_LEN_ERR = 7;
  localparam logic [9:0] CFG_RST = 10'h000;
  localparam logic [2:0] IRQ_SEL_RST = 3'h4;
  localparam logic [15:0] NULL_WORD = 16'h0000;
  // request hold time
  localparam int IRQ_HOLD_NS = 1600;
  localparam int CLK_NS = 25;
  localparam int IRQ_HOLD_CYC = (IRQ_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RX_CNT_W = 3;
  typedef enum logic [1:0] {IQP_RX_IDLE, IQP_RX_STAT, IQP_RX_LEN,
    IQP_RX_BODY} iqp_rx_st_t;
endpackage

// ---- rtl/iqp_host_port.sv ----
// isa i/o host port: register window, frame ports and event queue
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// two-entry buffer, head word held in a flip-flop
module iqp_buf2 #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] e0_r;
  logic [W-1:0] e1_r;
  logic v0_r;
  logic v1_r;
  logic push;
  logic pop;
  assign in_ready = ~v1_r;
  assign out_valid = v0_r;
  assign out_data = e0_r;
  assign push = in_valid & ~v1_r;
  assign pop = v0_r & out_ready;
  // shift on pop, fill lowest free slot on push
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      e0_r <= '0;
      e1_r <= '0;
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end else begin
      if (pop) begin
        e0_r <= (push && !v1_r) ? in_data : e1_r;
        v0_r <= v1_r | push;
        if (push && v1_r) e1_r <= in_data;
        v1_r <= 1'b0;
      end else if (push) begin
        if (!v0_r) begin
          e0_r <= in_data;
          v0_r <= 1'b1;
        end else begin
          e1_r <= in_data;
          v1_r <= 1'b1;
        end
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// top: isa slave, window registers, bid, receive readout, queue
module iqp_host_port #(
  parameter logic [15:0] IO_BASE = iqp_pkg::IO_BASE_RST,
  parameter int NUM_IRQ = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] sa,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [15:0] sd_in,
  output logic [15:0] sd_out,
  output logic sd_oe,
  output logic io_chrdy,
  output logic [NUM_IRQ-1:0] interrupt_request_pin,
  output logic [NUM_IRQ-1:0] interrupt_request_oe,
  output logic [15:0] transmit_command_word,
  output logic [15:0] transmit_length_word,
  output logic tx_bid_stb,
  input wire logic tx_space_available_now,
  input wire logic tx_request_length_error,
  output logic [15:0] tx_data,
  output logic tx_data_valid,
  input wire logic tx_data_ready,
  input wire logic rx_frame_start,
  input wire logic [15:0] rx_frame_status,
  input wire logic [15:0] rx_frame_length,
  input wire logic [15:0] rx_data,
  input wire logic rx_data_last,
  input wire logic rx_data_valid,
  output logic rx_data_ready,
  input wire logic rx_event_stb,
  input wire logic [9:0] rx_event_bits,
  input wire logic tx_event_stb,
  input wire logic [9:0] tx_event_bits,
  input wire logic buf_event_stb,
  input wire logic [9:0] buf_event_bits,
  input wire logic missed_frame_stb,
  input wire logic collision_stb
);
  localparam int HOLD_W = $clog2(iqp_pkg::IRQ_HOLD_CYC + 1);
  localparam logic [HOLD_W-1:0] HOLD_LD =
    HOLD_W'(iqp_pkg::IRQ_HOLD_CYC);

  logic hit;
  logic rd_act_r;
  logic wr_act_r;
  logic rd_go;
  logic wr_go;
  logic [3:0] ofs;
  logic [15:0] ptr_r;
  logic [11:0] dp_addr;
  logic [15:0] win_rd;
  logic [15:0] rd_word;
  logic [9:0] buf_cfg_r;
  logic [9:0] bus_ctl_r;
  logic [2:0] irq_sel_r;
  logic [9:0] rx_ev_r;
  logic [9:0] tx_ev_r;
  logic [9:0] buf_ev_r;
  logic [9:0] miss_cnt_r;
  logic [9:0] col_cnt_r;
  logic miss_rep_r;
  logic col_rep_r;
  logic [iqp_pkg::RX_CNT_W-1:0] rx_rep_r;
  logic [iqp_pkg::RX_CNT_W-1:0] tx_rep_r;
  logic buf_rep_r;
  logic [15:0] q_word;
  logic q_rd;
  logic q_empty;
  logic irq_r;
  logic hold_r;
  logic null_seen_r;
  logic [HOLD_W-1:0] hold_cnt_r;
  logic [15:0] rx_stat_r;
  logic [15:0] rx_len_r;
  iqp_pkg::iqp_rx_st_t rx_st_r;
  logic frame_rd;
  logic [16:0] rxb_data;
  logic rxb_valid;
  logic rx_pop;
  logic [15:0] txp_word_r;
  logic txp_v_r;
  logic txb_ready;
  logic buf_hit;

  ////////////////////////////////////////////////////////////////////////
  // address decode and cycle start detection
  // aen low and window hit
  assign hit = ~aen && (sa[15:4] == IO_BASE[15:4]);
  assign ofs = sa[3:0];
  assign rd_go = hit && !ior_n && !rd_act_r;
  assign wr_go = hit && !iow_n && !wr_act_r;
  assign q_rd = rd_go && (ofs == iqp_pkg::OFS_QUEUE);
  assign frame_rd = rd_go &&
    (ofs == iqp_pkg::OFS_FRAME0 || ofs == iqp_pkg::OFS_FRAME1);

  // one side effect per strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
    end else begin
      rd_act_r <= hit && !ior_n;
      wr_act_r <= hit && !iow_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register window pointer
  // port 1 is the word above port 0 while auto-increment is off; with it set, both ports use the pointer
  assign dp_addr = (ofs == iqp_pkg::OFS_DATA1 && !ptr_r[15]) ?
    ptr_r[11:0] + iqp_pkg::PTR_STEP : ptr_r[11:0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= '0;
    end else if (wr_go && ofs == iqp_pkg::OFS_PTR) begin
      ptr_r <= {sd_in[15], 3'b000, sd_in[11:0]};
    end else if ((rd_go || wr_go) && ptr_r[iqp_pkg::PTR_AINC_BIT] &&
                 (ofs == iqp_pkg::OFS_DATA0 ||
                  ofs == iqp_pkg::OFS_DATA1)) begin
      ptr_r[11:0] <= ptr_r[11:0] + iqp_pkg::PTR_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software-written configuration
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_cfg_r <= iqp_pkg::CFG_RST;
      bus_ctl_r <= iqp_pkg::CFG_RST;
      irq_sel_r <= iqp_pkg::IRQ_SEL_RST;
    end else if (wr_go && (ofs == iqp_pkg::OFS_DATA0 ||
                           ofs == iqp_pkg::OFS_DATA1)) begin
      unique case (dp_addr)
        iqp_pkg::A_BUF_CFG: buf_cfg_r <= sd_in[15:6];
        iqp_pkg::A_BUS_CTL: bus_ctl_r <= sd_in[15:6];
        iqp_pkg::A_IRQ_NUM: irq_sel_r <= sd_in[2:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit bid capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_command_word <= '0;
      transmit_length_word <= '0;
      tx_bid_stb <= 1'b0;
    end else begin
      tx_bid_stb <= wr_go && (ofs == iqp_pkg::OFS_TXLEN);
      if (wr_go && ofs == iqp_pkg::OFS_TRANSMIT_COMMAND_WORD)
        transmit_command_word <= sd_in;
      if (wr_go && ofs == iqp_pkg::OFS_TXLEN)
        transmit_length_word <= sd_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit frame words, stalled by io_chrdy when buffer is full
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txp_v_r <= 1'b0;
      txp_word_r <= '0;
      io_chrdy <= 1'b1;
    end else begin
      // frame port writes feed the buffer
      if (wr_go && (ofs == iqp_pkg::OFS_FRAME0 ||
                    ofs == iqp_pkg::OFS_FRAME1)) begin
        txp_v_r <= 1'b1;
        txp_word_r <= sd_in;
      end else if (txb_ready) begin
        txp_v_r <= 1'b0;
      end
      io_chrdy <= !(txp_v_r && !txb_ready);
    end
  end

  iqp_buf2 #(.W(16)) u_tx_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(txp_v_r),
    .in_ready(txb_ready),
    .in_data(txp_word_r),
    .out_valid(tx_data_valid),
    .out_ready(tx_data_ready),
    .out_data(tx_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // receive readout: status, length, then frame words
  iqp_buf2 #(.W(17)) u_rx_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(rx_data_valid),
    .in_ready(rx_data_ready),
    .in_data({rx_data_last, rx_data}),
    .out_valid(rxb_valid),
    .out_ready(rx_pop),
    .out_data(rxb_data)
  );

  // body words are frame data only
  assign rx_pop = frame_rd && rx_st_r == iqp_pkg::IQP_RX_BODY && rxb_valid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= iqp_pkg::IQP_RX_IDLE;
      rx_stat_r <= '0;
      rx_len_r <= '0;
    end else if (rx_frame_start) begin
      rx_st_r <= iqp_pkg::IQP_RX_STAT;
      rx_stat_r <= rx_frame_status;
      rx_len_r <= rx_frame_length;
    end else if (frame_rd) begin
      unique case (rx_st_r)
        iqp_pkg::IQP_RX_IDLE: rx_st_r <= iqp_pkg::IQP_RX_IDLE;
        iqp_pkg::IQP_RX_STAT: rx_st_r <= iqp_pkg::IQP_RX_LEN;
        iqp_pkg::IQP_RX_LEN: rx_st_r <= iqp_pkg::IQP_RX_BODY;
        iqp_pkg::IQP_RX_BODY:
          if (rx_pop && rxb_data[16]) rx_st_r <= iqp_pkg::IQP_RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event registers and report bookkeeping
  assign buf_hit = buf_event_stb && |buf_event_bits;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ev_r <= '0;
      tx_ev_r <= '0;
      buf_ev_r <= '0;
      rx_rep_r <= '0;
      tx_rep_r <= '0;
      buf_rep_r <= 1'b0;
    end else begin
      // clear the reported register; a new event wins
      if (q_rd && rx_rep_r != '0) begin
        rx_ev_r <= rx_event_stb ? rx_event_bits : '0;
        if (!rx_event_stb) rx_rep_r <= rx_rep_r - 1'b1;
      end else if (rx_event_stb) begin
        // set bits and queue a report
        rx_ev_r <= rx_ev_r | rx_event_bits;
        if (rx_rep_r != '1) rx_rep_r <= rx_rep_r + 1'b1;
      end
      if (q_rd && rx_rep_r == '0 && tx_rep_r != '0) begin
        tx_ev_r <= tx_event_stb ? tx_event_bits : '0;
        if (!tx_event_stb) tx_rep_r <= tx_rep_r - 1'b1;
      end else if (tx_event_stb) begin
        tx_ev_r <= tx_ev_r | tx_event_bits;
        if (tx_rep_r != '1) tx_rep_r <= tx_rep_r + 1'b1;
      end
      if (q_rd && q_word[5:0] == iqp_pkg::N_BUF_EV) begin
        buf_ev_r <= buf_hit ? buf_event_bits : '0;
        buf_rep_r <= buf_hit;
      end else if (buf_hit) begin
        buf_ev_r <= buf_ev_r | buf_event_bits;
        buf_rep_r <= 1'b1;
      end
    end
  end

  // counters whose wrap queues a single overflow report
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      miss_cnt_r <= '0;
      col_cnt_r <= '0;
      miss_rep_r <= 1'b0;
      col_rep_r <= 1'b0;
    end else begin
      if (missed_frame_stb) miss_cnt_r <= miss_cnt_r + 1'b1;
      if (collision_stb) col_cnt_r <= col_cnt_r + 1'b1;
      if (missed_frame_stb && miss_cnt_r == '1) miss_rep_r <= 1'b1;
      else if (q_rd && q_word[5:0] == iqp_pkg::N_MISS) miss_rep_r <= 1'b0;
      if (collision_stb && col_cnt_r == '1) col_rep_r <= 1'b1;
      else if (q_rd && q_word[5:0] == iqp_pkg::N_COL) col_rep_r <= 1'b0;
    end
  end

  always_comb begin
    if (rx_rep_r != '0) q_word = {rx_ev_r, iqp_pkg::N_RX_EV};
    else if (tx_rep_r != '0) q_word = {tx_ev_r, iqp_pkg::N_TX_EV};
    else if (buf_rep_r) q_word = {buf_ev_r, iqp_pkg::N_BUF_EV};
    else if (miss_rep_r) q_word = {miss_cnt_r, iqp_pkg::N_MISS};
    else if (col_rep_r) q_word = {col_cnt_r, iqp_pkg::N_COL};
    // empty queue gives the null word
    else q_word = iqp_pkg::NULL_WORD;
  end
  assign q_empty = (q_word == iqp_pkg::NULL_WORD);

  ////////////////////////////////////////////////////////////////////////
  // interrupt request with post-read hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
      hold_r <= 1'b0;
      null_seen_r <= 1'b0;
      hold_cnt_r <= '0;
    end else if (q_rd && irq_r) begin
      irq_r <= 1'b0;
      hold_r <= 1'b1;
      hold_cnt_r <= HOLD_LD;
      null_seen_r <= q_empty;
    end else if (hold_r) begin
      if (hold_cnt_r != '0) hold_cnt_r <= hold_cnt_r - 1'b1;
      if (q_rd && q_empty) null_seen_r <= 1'b1;
      // longer of null read and hold time
      if (hold_cnt_r == '0 && (null_seen_r || (q_rd && q_empty)))
        hold_r <= 1'b0;
    end else if (!q_empty && bus_ctl_r[iqp_pkg::BUS_CTL_IRQ_EN - 6] &&
                 (rx_rep_r != '0 || tx_rep_r != '0 || miss_rep_r ||
                  col_rep_r || |(buf_ev_r & buf_cfg_r))) begin
      // buffer events need their config enable
      irq_r <= 1'b1;
    end
  end

  // route to the selected pin or float all
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          interrupt_request_pin[gi] <= 1'b0;
          interrupt_request_oe[gi] <= 1'b0;
        end else begin
          interrupt_request_oe[gi] <= (irq_sel_r < 3'(NUM_IRQ));
          interrupt_request_pin[gi] <= irq_r && (irq_sel_r == 3'(gi));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read data selection
  always_comb begin
    unique case (dp_addr)
      iqp_pkg::A_IRQ_NUM: win_rd = {13'h0000, irq_sel_r};
      iqp_pkg::A_BUF_CFG: win_rd = {buf_cfg_r, iqp_pkg::N_BUF_CFG};
      iqp_pkg::A_BUS_CTL: win_rd = {bus_ctl_r, iqp_pkg::N_BUS_CTL};
      iqp_pkg::A_QUEUE: win_rd = q_word;
      iqp_pkg::A_RX_EV: win_rd = {rx_ev_r, iqp_pkg::N_RX_EV};
      iqp_pkg::A_TX_EV: win_rd = {tx_ev_r, iqp_pkg::N_TX_EV};
      iqp_pkg::A_BUF_EV: win_rd = {buf_ev_r, iqp_pkg::N_BUF_EV};
      iqp_pkg::A_MISS: win_rd = {miss_cnt_r, iqp_pkg::N_MISS};
      iqp_pkg::A_COL: win_rd = {col_cnt_r, iqp_pkg::N_COL};
      iqp_pkg::A_BUS_ST: win_rd = {7'h00, tx_space_available_now,
        tx_request_length_error, 1'b0, iqp_pkg::N_BUS_ST};
      iqp_pkg::A_RX_STAT: win_rd = rx_stat_r;
      iqp_pkg::A_RX_LEN: win_rd = rx_len_r;
      default: win_rd = '0;
    endcase
  end

  always_comb begin
    unique case (ofs)
      iqp_pkg::OFS_FRAME0, iqp_pkg::OFS_FRAME1:
        unique case (rx_st_r)
          iqp_pkg::IQP_RX_STAT: rd_word = rx_stat_r;
          iqp_pkg::IQP_RX_LEN: rd_word = rx_len_r;
          iqp_pkg::IQP_RX_BODY: rd_word = rxb_valid ? rxb_data[15:0] : '0;
          default: rd_word = '0;
        endcase
      iqp_pkg::OFS_QUEUE: rd_word = q_word;
      iqp_pkg::OFS_PTR: rd_word = {ptr_r[15], iqp_pkg::PTR_FIXED,
                                   ptr_r[11:0]};
      iqp_pkg::OFS_DATA0, iqp_pkg::OFS_DATA1: rd_word = win_rd;
      default: rd_word = '0;
    endcase
  end

  // data latched at strobe start, driven while strobe low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_out <= '0;
      sd_oe <= 1'b0;
    end else begin
      if (rd_go) sd_out <= rd_word;
      // enabled only while the read strobe is low inside the IO_BASE window
      sd_oe <= hit && !ior_n;
    end
  end
endmodule

// ---- tb/iqp_host_port_asserts.sv ----
// concurrent checks on the host port pins
`timescale 1ns/1ps
module iqp_host_port_asserts #(
  parameter logic [15:0] IO_BASE = 16'h0300,
  parameter int NUM_IRQ = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] sa,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [15:0] sd_in,
  input wire logic [15:0] sd_out,
  input wire logic sd_oe,
  input wire logic [NUM_IRQ-1:0] interrupt_request_pin,
  input wire logic [NUM_IRQ-1:0] interrupt_request_oe,
  input wire logic [15:0] transmit_length_word,
  input wire logic tx_bid_stb,
  input wire logic [15:0] tx_data,
  input wire logic tx_data_valid,
  input wire logic tx_data_ready
);
  logic hit, rd_take, wr_take, q_take, len_take, rd_prev_r, wr_prev_r;
  logic [6:0] hold_r;
  // strobe start in window
  assign hit = !aen && sa[15:4] == IO_BASE[15:4];
  assign rd_take = hit && !ior_n && !rd_prev_r;
  assign wr_take = hit && !iow_n && !wr_prev_r;
  assign q_take = rd_take && sa[3:0] == 4'h8;
  assign len_take = wr_take && sa[3:0] == 4'h6;
  // strobe history, post-read hold count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      hold_r <= 7'h00;
    end else begin
      rd_prev_r <= !ior_n;
      wr_prev_r <= !iow_n;
      if (q_take && interrupt_request_pin != '0) hold_r <= 7'h40;
      else if (hold_r != 7'h00) hold_r <= hold_r - 7'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  read_drive_a: assert property (
    sd_oe |-> $past(hit && !ior_n)) else $error("drive without read");
  irq_oe_group_a: assert property (
    interrupt_request_oe == '0 || interrupt_request_oe == '1)
    else $error("enables split");
  irq_one_pin_a: assert property (
    $onehot0(interrupt_request_pin) &&
    (interrupt_request_pin & ~interrupt_request_oe) == '0)
    else $error("request pin wrong");
  bid_after_len_a: assert property (
    tx_bid_stb |-> $past(len_take) || $past(len_take, 2))
    else $error("stray bid");
  len_capture_a: assert property (
    len_take |=> ##1 transmit_length_word == $past(sd_in, 2))
    else $error("length lost");
  irq_hold_a: assert property (
    hold_r inside {[1:60]} |-> interrupt_request_pin == '0)
    else $error("early request");
  queue_word_a: assert property (
    q_take |=> sd_out[5:0] inside {6'h00, 6'h04, 6'h08, 6'h0c, 6'h10,
    6'h12} && (sd_out[5:0] != 6'h00 || sd_out == 16'h0000))
    else $error("bad queue word");
  ptr_fixed_a: assert property (
    rd_take && sa[3:0] == 4'ha |=> sd_out[14:12] == 3'b011)
    else $error("pointer bits");
  buf_hold_a: assert property (
    tx_data_valid && !tx_data_ready |=> tx_data_valid && $stable(tx_data))
    else $error("stalled word lost");
  cover property (q_take && interrupt_request_pin != '0);
  cover property (tx_data_valid && !tx_data_ready ##1 tx_data_ready);
  cover property (tx_bid_stb);
endmodule
bind iqp_host_port iqp_host_port_asserts #(.IO_BASE(IO_BASE),
  .NUM_IRQ(NUM_IRQ)) chk_u (.*);

// ---- tb/iqp_host_bfm.sv ----
// isa host model driving i/o read and write cycles
`timescale 1ns/1ps
module iqp_host_bfm (
  input wire logic ref_clk,
  input wire logic [15:0] sd_out,
  input wire logic io_chrdy,
  output logic [15:0] sa,
  output logic aen,
  output logic ior_n,
  output logic iow_n,
  output logic [15:0] sd_in,
  output logic hang
);
  // idle bus from time zero
  initial begin
    {sa, sd_in} = '0;
    {aen, ior_n, iow_n, hang} = 4'he;
  end
  ////////////////////////////////////////////////////////////////////////////
  // write: wait for room, strobe two edges
  task automatic wr(input logic [15:0] a, input logic [15:0] v,
    input logic off);
    int n;
    n = 0;
    while (io_chrdy !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 300) hang <= 1'b1;
    @(posedge ref_clk);
    sa <= a;
    aen <= off;
    sd_in <= v;
    iow_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    iow_n <= 1'b1;
    aen <= 1'b1;
    sd_in <= ~v; // released data line shows the inverse
    @(posedge ref_clk);
  endtask
  // read: word taken as strobe ends
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    sa <= a;
    aen <= 1'b0;
    ior_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    v = sd_out;
    ior_n <= 1'b1;
    aen <= 1'b1;
    @(posedge ref_clk);
  endtask
endmodule

// ---- tb/iqp_host_port_tb.sv ----
// self-checking bench for the isa host port
`timescale 1ns/1ps
module iqp_host_port_tb;
  localparam logic [15:0] BASE = 16'h0300;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] sa, sd_in, sd_out, transmit_command_word, d, tx_data;
  logic [15:0] transmit_length_word, rx_frame_status, rx_frame_length;
  logic [15:0] rx_data, tx_got[$];
  logic [16:0] rx_q[$];
  logic aen, ior_n, iow_n, sd_oe, io_chrdy, tx_bid_stb, hang;
  logic tx_space_available_now, tx_request_length_error, tx_data_valid;
  logic tx_data_ready, rx_frame_start, rx_data_last, rx_data_valid;
  logic rx_data_ready, rx_event_stb, tx_event_stb, buf_event_stb;
  logic missed_frame_stb, collision_stb;
  logic [9:0] rx_event_bits, tx_event_bits, buf_event_bits;
  logic [3:0] interrupt_request_pin, interrupt_request_oe;
  int failures = 0;
  int checked = 0;
  int bids = 0;
  iqp_host_port #(.IO_BASE(BASE), .NUM_IRQ(4)) dut_u (.*);
  iqp_host_bfm host_u (.*);
  always #12.5 ref_clk = ~ref_clk;
  // rx source, tx sink, bid count
  always @(posedge ref_clk) begin
    if (rx_data_valid && rx_data_ready) void'(rx_q.pop_front());
    rx_data_valid <= rx_q.size() > 0;
    {rx_data_last, rx_data} <= rx_q.size() > 0 ? rx_q[0] :
      ~{rx_data_last, rx_data};
    if (tx_data_valid === 1'b1 && tx_data_ready === 1'b1)
      tx_got.push_back(tx_data);
    if (tx_bid_stb === 1'b1) bids++;
  end
  always @(posedge hang) begin
    failures++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic w(input logic [3:0] o, input logic [15:0] v);
    host_u.wr({BASE[15:4], o}, v, 1'b0);
  endtask
  task automatic r(input logic [3:0] o);
    host_u.rd({BASE[15:4], o}, d);
  endtask
  task automatic ev(input logic [4:0] s, input logic [9:0] b, input int k);
    repeat (k) begin
      @(posedge ref_clk);
      {collision_stb, missed_frame_stb, buf_event_stb, tx_event_stb,
        rx_event_stb} <= s;
      {rx_event_bits, tx_event_bits, buf_event_bits} <= {3{b}};
      @(posedge ref_clk);
      {collision_stb, missed_frame_stb, buf_event_stb, tx_event_stb,
        rx_event_stb} <= 5'h00;
    end
  endtask
  task automatic wpin();
    int n;
    n = 0;
    while (interrupt_request_pin[0] !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk("irq raised", interrupt_request_pin, 4'h1);
    if (n == 200) test_done();
  endtask
  task automatic t_ptr();
    w(4'ha, 16'h1138);
    r(4'ha);
    chk("pointer", d, 16'h3138);
    host_u.wr(16'h031a, 16'h0022, 1'b0);
    host_u.wr({BASE[15:4], 4'ha}, 16'h0022, 1'b1);
    r(4'hc);
    chk("space bit", d[8], 1'b1);
    r(4'ha);
    chk("pointer kept", d, 16'h3138);
    w(4'ha, 16'h0136);
    r(4'he);
    chk("port one", d[8], 1'b1);
    w(4'ha, 16'h8136);
    r(4'hc);
    r(4'hc);
    chk("stepped read", d[8], 1'b1);
    r(4'ha);
    chk("stepped pointer", d, 16'hb13a);
  endtask
  task automatic t_bid();
    tx_space_available_now <= 1'b0;
    tx_request_length_error <= 1'b1;
    w(4'ha, 16'h0138);
    r(4'hc);
    chk("bus state", d[8:7], 2'b01);
    w(4'h4, 16'h00c0);
    w(4'h6, 16'h05ea);
    repeat (2) @(posedge ref_clk);
    chk("command", transmit_command_word, 16'h00c0);
    chk("length", transmit_length_word, 16'h05ea);
    chk("bids", 16'(bids), 16'h0001);
    tx_space_available_now <= 1'b1;
    tx_request_length_error <= 1'b0;
  endtask
  task automatic t_frame();
    int n;
    n = 0;
    tx_data_ready <= 1'b0;
    for (int i = 0; i < 3; i++) w(4'h0, 16'(16'h5a00 + i));
    repeat (2) @(posedge ref_clk);
    chk("buffer full", io_chrdy, 1'b0);
    tx_data_ready <= 1'b1;
    w(4'h0, 16'h5a03);
    while (tx_got.size() < 4 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50) begin
      failures++;
      test_done();
    end
    for (int i = 0; i < 4; i++)
      chk("frame word", tx_got[i], 16'(16'h5a00 + i));
    @(posedge ref_clk);
    chk("drained", tx_data_valid, 1'b0);
  endtask
  task automatic t_rx();
    logic [15:0] e[5] = '{16'h1234, 16'h0004, 16'ha1a2, 16'hb1b2, 16'h0};
    {rx_frame_status, rx_frame_length, rx_frame_start} <= 33'h024680009;
    @(posedge ref_clk);
    rx_frame_start <= 1'b0;
    rx_q = '{17'h0a1a2, 17'h1b1b2};
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      r(4'h0);
      chk("receive word", d, e[i]);
    end
  endtask
  task automatic t_queue();
    logic [15:0] e[6] = '{16'h0104, 16'h0208, 16'h010c, 16'h0010,
      16'h0012, 16'h0};
    w(4'ha, 16'h0116);
    w(4'hc, 16'h8000);
    w(4'ha, 16'h0022);
    w(4'hc, 16'h0000);
    w(4'ha, 16'h010a);
    w(4'hc, 16'h0100);
    ev(5'h10, 10'h000, 1024);
    ev(5'h08, 10'h000, 1024);
    ev(5'h04, 10'h004, 1);
    ev(5'h02, 10'h008, 1);
    ev(5'h01, 10'h004, 1);
    wpin();
    chk("irq enables", interrupt_request_oe, 4'hf);
    for (int i = 0; i < 6; i++) begin
      r(4'h8);
      chk("queue word", d, e[i]);
    end
    chk("irq dropped", interrupt_request_pin, 4'h0);
    ev(5'h04, 10'h004, 2);
    wpin();
    ev(5'h10, 10'h000, 2048);
    r(4'h8);
    chk("one buf report", d, 16'h010c);
    r(4'h8);
    chk("one col report", d, 16'h0012);
    r(4'h8);
    chk("queue empty", d, 16'h0000);
    w(4'ha, 16'h0022);
    w(4'hc, 16'h0004);
    repeat (2) @(posedge ref_clk);
    chk("irq floated", interrupt_request_oe, 4'h0);
  endtask
  initial begin
    {tx_request_length_error, tx_data_ready, rx_frame_start, rx_data_last,
      rx_data_valid, rx_event_stb, tx_event_stb, buf_event_stb,
      missed_frame_stb, collision_stb} = '0;
    {rx_frame_status, rx_frame_length, rx_data} = '0;
    {rx_event_bits, tx_event_bits, buf_event_bits} = '0;
    tx_space_available_now = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("reset pins", {sd_oe, io_chrdy, tx_data_valid, rx_data_ready,
      interrupt_request_oe, interrupt_request_pin}, 16'h0500);
    t_ptr();
    t_bid();
    t_frame();
    t_rx();
    t_queue();
    test_done();
  end
endmodule
